// ### shared/shci_consts.svh
// Constants of the sensor host command interface
`ifndef SHCI_CONSTS_SVH
`define SHCI_CONSTS_SVH
`define SHCI_OP_RUN 4'h1
`define SHCI_OP_WATCH 4'h2
`define SHCI_OP_ONE 4'h3
`define SHCI_OP_FETCH 4'h4
`define SHCI_OP_CFG_RD 4'h5
`define SHCI_OP_CFG_WR 4'h6
`define SHCI_OP_LEAVE 8'h80
`define SHCI_OP_LOAD 8'hd0
`define SHCI_OP_SAVE 8'he0
`define SHCI_OP_INIT 8'hf0
`define SHCI_LEN_ONE 3'h1
`define SHCI_LEN_CFG_RD 3'h2
`define SHCI_LEN_CFG_WR 3'h4
`define SHCI_LOCK_SPI 2'h2
`define SHCI_LOCK_I2C 2'h3
`define SHCI_CFG_PROT 6'h20
`define SHCI_LAST_IDX 4'h8
`endif

// ### shared/shci_pkg.sv
// Types shared by the host command interface
package shci_pkg;
`include "shci_consts.svh"
   typedef struct packed {
      logic continuous_run_flag;
      logic change_watch_flag;
      logic one_shot_flag;
      logic fault_flag;
      logic fixed_bit_flag;
      logic came_from_init_flag;
      logic [1:0] reply_len;
   } shci_status_t;
   typedef logic [3:0][15:0] shci_sample_t;
   typedef logic [8:0][7:0] shci_reply_t;
   typedef struct packed {
      logic [7:0] data;
      logic first;
   } shci_rx_t;
   typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_WR, I2C_RD, I2C_MACK} shci_i2c_st_t;
   typedef struct packed {
      logic [6:0] sh;
      logic [2:0] bitc;
      logic [2:0] nbyte;
      logic [7:0] op;
      logic first;
      logic tx;
      logic [3:0] idx;
   } shci_link_st_t;
   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic [1:0] pin_s;
      logic [2:0] trg_s;
      logic [2:0] rxt_s;
      logic [2:0] txt_s;
      logic scl_d;
      logic sda_d;
      shci_i2c_st_t ist;
      logic [7:0] ish;
      logic [3:0] ibit;
      logic irw;
      logic imack;
      logic ifirst;
      logic ioe;
      logic [3:0] idx;
      logic [3:0][7:0] cbuf;
      logic [2:0] cnt;
      logic src;
      logic exec;
      logic run;
      logic watch;
      logic one;
      logic ready;
      logic init;
      logic lk_valid;
      logic lk_i2c;
      shci_reply_t reply;
      logic meas_start;
      logic [3:0] meas_axes;
      logic nvm_load;
      logic nvm_save;
      logic cfg_we;
      logic [5:0] cfg_addr;
      logic [15:0] cfg_wdata;
   } shci_core_st_t;
   // Command length in bytes, known from the opcode byte alone
   function automatic logic [2:0] shci_cmd_len(input logic [7:0] op);
      if (op[7:4] == `SHCI_OP_CFG_RD) begin
         return `SHCI_LEN_CFG_RD;
      end
      if (op[7:4] == `SHCI_OP_CFG_WR) begin
         return `SHCI_LEN_CFG_WR;
      end
      return `SHCI_LEN_ONE;
   endfunction : shci_cmd_len
endpackage : shci_pkg

// ### rtl/shci_spi_link.sv
// SPI mode 3 byte shifter running on the link clock
`timescale 1ns/1ps
module shci_spi_link (
   // Link clock and frame
   input wire logic ser_clk,
   input wire logic proto_sel_pin,
   input wire logic rst,
   // Shared data pin
   input wire logic data_i,
   output logic data_o,
   output logic data_oe,
   // Core side
   input wire shci_pkg::shci_reply_t reply,
   output shci_pkg::shci_rx_t rx,
   output logic rx_tgl,
   output logic tx_tgl
);
   shci_pkg::shci_link_st_t f;
   shci_pkg::shci_link_st_t fn;
   shci_pkg::shci_rx_t rx_next;
   logic rx_tgl_next;
   logic tx_tgl_next;
   logic frame_rst;
   logic [7:0] byte_in;
   logic [7:0] tx_byte;

   // Frame state dies with chip select; sck keeps toggling as SCL outside frames
   assign frame_rst = rst | proto_sel_pin;
   assign byte_in = {f.sh, data_i};
   assign tx_byte = reply[f.idx];

   always_comb begin
      fn = f;
      rx_next = rx;
      rx_tgl_next = rx_tgl;
      tx_tgl_next = tx_tgl;
      fn.bitc = f.bitc + 3'h1;
      fn.sh = byte_in[6:0];
      if (f.bitc == 3'h7) begin
         if (f.tx) begin
            if (f.idx == 4'h0) begin
               tx_tgl_next = ~tx_tgl;
            end
            if (f.idx != `SHCI_LAST_IDX) begin
               fn.idx = f.idx + 4'h1;
            end
         end else begin
            rx_next = '{data: byte_in, first: f.first};
            rx_tgl_next = ~rx_tgl;
            fn.first = 1'b0;
            fn.nbyte = f.nbyte + 3'h1;
            if (f.first) begin
               fn.op = byte_in;
            end
            if (fn.nbyte == shci_pkg::shci_cmd_len(f.first ? byte_in : f.op)) begin
               fn.tx = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ser_clk or posedge frame_rst) begin
      if (frame_rst) begin
         f <= '0;
         f.first <= 1'b1;
      end else begin
         f <= fn;
      end
   end

   // Held across frame end so the core can still pick them up
   always_ff @(posedge ser_clk or posedge rst) begin
      if (rst) begin
         rx <= '0;
         rx_tgl <= 1'b0;
         tx_tgl <= 1'b0;
      end else begin
         rx <= rx_next;
         rx_tgl <= rx_tgl_next;
         tx_tgl <= tx_tgl_next;
      end
   end

   // MSB first, changed on leading falling edge
   always_ff @(negedge ser_clk or posedge frame_rst) begin
      if (frame_rst) begin
         data_o <= 1'b0;
         data_oe <= 1'b0;
      end else begin
         data_o <= tx_byte[~f.bitc];
         data_oe <= f.tx;
      end
   end
endmodule : shci_spi_link

// ### rtl/shci_core.sv
// Host command front end: I2C slave, SPI crossing, command decode and status
`timescale 1ns/1ps
module shci_core (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Serial pins
   input wire logic proto_sel_pin,
   input wire logic ser_clk,
   input wire logic data_i,
   output logic data_o,
   output logic data_oe,
   // Stored configuration
   input wire logic [1:0] iface_lock_field,
   input wire logic [4:0] stored_addr_bits,
   input wire logic [1:0] addr_pins,
   input wire logic [3:0] default_axes,
   input wire logic trig_enable,
   input wire logic trigger_pin,
   // Memory health
   input wire logic ecc_double,
   input wire logic ecc_single,
   // Configuration word access
   output logic [5:0] cfg_addr,
   output logic [15:0] cfg_wdata,
   output logic cfg_we,
   input wire logic [15:0] cfg_rdata,
   output logic nvm_load_pulse,
   output logic nvm_save_pulse,
   // Measurement sequencer
   output logic meas_start,
   output logic [3:0] meas_axes,
   input wire logic sample_done,
   input wire shci_pkg::shci_sample_t sample,
   // Mode and readiness
   output logic continuous_run_flag,
   output logic change_watch_flag,
   output logic one_shot_flag,
   output logic sample_ready_signal
);
   shci_pkg::shci_core_st_t s;
   shci_pkg::shci_core_st_t n;
   shci_pkg::shci_rx_t spi_rx;
   shci_pkg::shci_status_t st;
   logic spi_rx_tgl;
   logic spi_tx_tgl;
   logic spi_o;
   logic spi_oe;
   logic scl;
   logic sda;
   logic rise;
   logic fall;
   logic i2c_en;
   logic i2c_stb;
   logic rd0;
   logic stb;
   logic take;
   logic first_b;
   logic refuse;
   logic late;
   logic allow_i2c;
   logic allow_spi;
   logic [7:0] rx_b;
   logic [7:0] op;
   logic [2:0] pos;
   logic [2:0] k;
   logic [1:0] dlen;

   shci_spi_link u_link (
      .ser_clk(ser_clk),
      .proto_sel_pin(proto_sel_pin),
      .rst(rst),
      .data_i(data_i),
      .data_o(spi_o),
      .data_oe(spi_oe),
      .reply(s.reply),
      .rx(spi_rx),
      .rx_tgl(spi_rx_tgl),
      .tx_tgl(spi_tx_tgl)
   );

   always_comb begin
      if (iface_lock_field == `SHCI_LOCK_I2C) begin
         allow_i2c = 1'b1;
         allow_spi = 1'b0;
      end else if (iface_lock_field == `SHCI_LOCK_SPI) begin
         allow_i2c = 1'b0;
         allow_spi = 1'b1;
      end else begin
         allow_i2c = ~s.lk_valid | s.lk_i2c;
         allow_spi = ~s.lk_valid | ~s.lk_i2c;
      end
   end

   // SPI frame state releases its driver itself, so no pin read is needed here
   assign data_o = spi_oe ? spi_o : 1'b0;
   assign data_oe = spi_oe | s.ioe;

   always_comb begin
      n = s;
      n.exec = 1'b0;
      n.meas_start = 1'b0;
      n.cfg_we = 1'b0;
      n.nvm_load = 1'b0;
      n.nvm_save = 1'b0;
      n.scl_s = {s.scl_s[0], ser_clk};
      n.sda_s = {s.sda_s[0], data_i};
      n.pin_s = {s.pin_s[0], proto_sel_pin};
      n.trg_s = {s.trg_s[1:0], trigger_pin};
      n.rxt_s = {s.rxt_s[1:0], spi_rx_tgl};
      n.txt_s = {s.txt_s[1:0], spi_tx_tgl};
      scl = s.scl_s[1];
      sda = s.sda_s[1];
      n.scl_d = scl;
      n.sda_d = sda;
      rise = scl & ~s.scl_d;
      fall = ~scl & s.scl_d;
      i2c_en = s.pin_s[1] & allow_i2c;
      i2c_stb = 1'b0;
      rd0 = 1'b0;
      refuse = 1'b0;
      late = 1'b0;
      dlen = 2'h0;
      k = 3'h0;
      pos = 3'h0;
      op = s.cbuf[0];

      // I2C slave, oversampled; 400 kHz leaves ample margin
      if (!i2c_en) begin
         n.ist = shci_pkg::I2C_IDLE;
         n.ioe = 1'b0;
      end else if (scl && s.scl_d && s.sda_d && !sda) begin
         n.ist = shci_pkg::I2C_ADDR;
         n.ibit = 4'h0;
         n.ioe = 1'b0;
      end else if (scl && s.scl_d && !s.sda_d && sda) begin
         n.ist = shci_pkg::I2C_IDLE;
         n.ioe = 1'b0;
      end else if (rise) begin
         n.ibit = s.ibit + 4'h1;
         n.ish = {s.ish[6:0], sda};
         if (s.ist == shci_pkg::I2C_MACK) begin
            n.imack = ~sda;
         end
      end else if (fall) begin
         case (s.ist)
            shci_pkg::I2C_ADDR: begin
               // address from stored bits and pins
               if (s.ibit == 4'h8) begin
                  if (s.ish[7:1] == {stored_addr_bits, addr_pins}) begin
                     n.ist = shci_pkg::I2C_ACK;
                     n.ioe = 1'b1;
                     n.irw = s.ish[0];
                     n.ifirst = ~s.ish[0];
                     n.idx = 4'h0;
                  end else begin
                     n.ist = shci_pkg::I2C_IDLE;
                  end
               end
            end
            shci_pkg::I2C_ACK: begin
               n.ibit = 4'h0;
               if (s.irw) begin
                  n.ist = shci_pkg::I2C_RD;
                  n.ioe = ~s.reply[s.idx][7];
               end else begin
                  n.ist = shci_pkg::I2C_WR;
                  n.ioe = 1'b0;
               end
            end
            shci_pkg::I2C_WR: begin
               if (s.ibit == 4'h8) begin
                  n.ist = shci_pkg::I2C_ACK;
                  n.ioe = 1'b1;
                  n.ifirst = 1'b0;
                  i2c_stb = 1'b1;
               end
            end
            shci_pkg::I2C_RD: begin
               if (s.ibit == 4'h8) begin
                  n.ist = shci_pkg::I2C_MACK;
                  n.ioe = 1'b0;
                  rd0 = (s.idx == 4'h0);
                  if (s.idx != `SHCI_LAST_IDX) begin
                     n.idx = s.idx + 4'h1;
                  end
               end else begin
                  n.ioe = ~s.reply[s.idx][3'(4'h7 - s.ibit)];
               end
            end
            shci_pkg::I2C_MACK: begin
               // Master nack ends the reply
               if (s.imack) begin
                  n.ist = shci_pkg::I2C_RD;
                  n.ibit = 4'h0;
                  n.ioe = ~s.reply[s.idx][7];
               end else begin
                  n.ist = shci_pkg::I2C_IDLE;
               end
            end
            default: begin
               n.ist = shci_pkg::I2C_IDLE;
            end
         endcase
      end

      // SPI bytes cross by toggle; the held byte is stable for a whole byte time
      stb = i2c_stb | ((s.rxt_s[1] ^ s.rxt_s[2]) & allow_spi);
      rx_b = i2c_stb ? s.ish : spi_rx.data;
      first_b = i2c_stb ? s.ifirst : spi_rx.first;
      rd0 = rd0 | (s.txt_s[1] ^ s.txt_s[2]);

      if (rd0) begin
         n.init = 1'b0;
      end

      // each select frame starts a new command
      take = stb & (first_b | (s.cnt != 3'h0));
      if (take) begin
         pos = first_b ? 3'h0 : s.cnt;
         n.cbuf[pos[1:0]] = rx_b;
         n.cnt = pos + 3'h1;
         if (first_b) begin
            n.src = i2c_stb;
         end else begin
            n.cfg_addr = rx_b[7:2];
         end
         if (n.cnt == shci_pkg::shci_cmd_len(first_b ? rx_b : s.cbuf[0])) begin
            n.exec = 1'b1;
            n.cnt = 3'h0;
         end
      end

      // One-shot ends when its conversion completes
      if (sample_done) begin
         n.one = 1'b0;
      end

      if (s.exec) begin
         // double fault refuses all but soft reset
         if (ecc_double && op != `SHCI_OP_INIT) begin
            refuse = 1'b1;
         end else begin
            case (op[7:4])
               `SHCI_OP_RUN, `SHCI_OP_WATCH, `SHCI_OP_ONE: begin
                  // any active mode refuses a mode command; all mode flags stay as they were
                  if (s.run || s.watch || s.one) begin
                     refuse = 1'b1;
                  end else begin
                     n.run = (op[7:4] == `SHCI_OP_RUN);
                     n.watch = (op[7:4] == `SHCI_OP_WATCH);
                     n.one = (op[7:4] == `SHCI_OP_ONE);
                     n.meas_start = 1'b1;
                     n.meas_axes = (op[3:0] == 4'h0) ? default_axes : op[3:0];
                  end
               end
               `SHCI_OP_FETCH: begin
                  if (op[3:0] == 4'h0) begin
                     refuse = 1'b1;
                  end else begin
                     late = ~s.ready;
                     n.ready = 1'b0;
                     // components in T X Y Z order
                     for (int i = 0; i < 4; i++) begin
                        if (op[i]) begin
                           n.reply[{k, 1'b0} + 4'h1] = sample[i][15:8];
                           n.reply[{k, 1'b0} + 4'h2] = sample[i][7:0];
                           k = k + 3'h1;
                        end
                     end
                     // length code D = words - 1
                     dlen = 2'(k - 3'h1);
                  end
               end
               `SHCI_OP_CFG_RD: begin
                  // argument and low address bits zero
                  if (op[3:0] != 4'h0 || s.cbuf[1][1:0] != 2'h0) begin
                     refuse = 1'b1;
                  end else begin
                     n.reply[1] = cfg_rdata[15:8];
                     n.reply[2] = cfg_rdata[7:0];
                  end
               end
               `SHCI_OP_CFG_WR: begin
                  if (op[3:0] != 4'h0 || s.cbuf[3][1:0] != 2'h0 || s.cfg_addr >= `SHCI_CFG_PROT) begin
                     refuse = 1'b1;
                  end else begin
                     n.cfg_we = 1'b1;
                     n.cfg_wdata = {s.cbuf[1], s.cbuf[2]};
                  end
               end
               default: begin
                  case (op)
                     `SHCI_OP_LEAVE: begin
                        n.run = 1'b0;
                        n.watch = 1'b0;
                        n.one = 1'b0;
                        n.ready = 1'b0;
                     end
                     `SHCI_OP_LOAD: begin
                        n.nvm_load = 1'b1;
                     end
                     `SHCI_OP_SAVE: begin
                        n.nvm_save = 1'b1;
                     end
                     `SHCI_OP_INIT: begin
                        n.run = 1'b0;
                        n.watch = 1'b0;
                        n.one = 1'b0;
                        n.ready = 1'b0;
                        n.lk_valid = 1'b0;
                        n.init = 1'b1;
                        n.nvm_load = 1'b1;
                     end
                     default: begin
                        refuse = 1'b1;
                     end
                  endcase
               end
            endcase
         end
         if (!refuse && !s.lk_valid && op != `SHCI_OP_INIT) begin
            n.lk_valid = 1'b1;
            n.lk_i2c = s.src;
         end
      end

      st = '{continuous_run_flag: n.run,
             change_watch_flag: n.watch,
             one_shot_flag: n.one,
             fault_flag: refuse | late | ecc_double,
             fixed_bit_flag: ecc_single,
             came_from_init_flag: n.init,
             reply_len: dlen};
      // status for all but soft reset
      if (s.exec && op != `SHCI_OP_INIT) begin
         n.reply[0] = st;
      end

      if (s.trg_s[1] && !s.trg_s[2] && trig_enable && !ecc_double && !(n.run || n.watch || n.one)) begin
         n.one = 1'b1;
         n.meas_start = 1'b1;
         n.meas_axes = default_axes;
      end

      // New data wins over a clear in the same cycle
      if (sample_done) begin
         n.ready = 1'b1;
      end
   end

   // Reset release leaves the reset flag raised
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.init <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign cfg_addr = s.cfg_addr;
   assign cfg_wdata = s.cfg_wdata;
   assign cfg_we = s.cfg_we;
   assign nvm_load_pulse = s.nvm_load;
   assign nvm_save_pulse = s.nvm_save;
   assign meas_start = s.meas_start;
   assign meas_axes = s.meas_axes;
   assign continuous_run_flag = s.run;
   assign change_watch_flag = s.watch;
   assign one_shot_flag = s.one;
   assign sample_ready_signal = s.ready;
endmodule : shci_core

// ### dv/shci_core_asserts.sv
// Port assertions for the host command interface
`timescale 1ns/1ps
module shci_core_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Watched ports
   input wire logic proto_sel_pin,
   input wire logic [1:0] iface_lock_field,
   input wire logic data_oe,
   input wire logic ecc_double,
   input wire logic sample_done,
   input wire logic [5:0] cfg_addr,
   input wire logic cfg_we,
   input wire logic nvm_load_pulse,
   input wire logic nvm_save_pulse,
   input wire logic meas_start,
   input wire logic continuous_run_flag,
   input wire logic change_watch_flag,
   input wire logic one_shot_flag
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   a_run_start: assert property ($rose(continuous_run_flag) |-> meas_start)
      else $error("run without start");
   a_one_mode: assert property ($onehot0({continuous_run_flag, change_watch_flag, one_shot_flag}))
      else $error("two modes set");
   a_we_pulse: assert property (cfg_we |=> !cfg_we)
      else $error("write strobe too long");
   a_we_area: assert property (cfg_we |-> cfg_addr < 6'h20)
      else $error("protected word written");
   a_one_done: assert property (one_shot_flag && sample_done |=> !one_shot_flag || meas_start)
      else $error("one-shot flag stuck");
   a_ecc_block: assert property (ecc_double && $past(ecc_double) |-> !(meas_start || cfg_we || nvm_save_pulse))
      else $error("command run in fault");
   a_nvm_pulse: assert property (nvm_load_pulse |-> !nvm_save_pulse ##1 !nvm_load_pulse)
      else $error("memory pulse wrong");
   // Locked to SPI the pin high must leave the line undriven
   a_spi_quiet: assert property ((iface_lock_field == 2'h2 && proto_sel_pin) [*3] |-> !data_oe)
      else $error("line driven while idle");
   c_run: cover property ($rose(continuous_run_flag));
   c_write: cover property (cfg_we);
   c_shot: cover property ($rose(one_shot_flag) ##[1:200] sample_done);
   c_i2c: cover property (iface_lock_field == 2'h3 && data_oe);
endmodule : shci_core_asserts

bind shci_core shci_core_asserts shci_core_asserts_i (.core_clk, .rst, .proto_sel_pin, .iface_lock_field,
   .data_oe, .ecc_double, .sample_done, .cfg_addr, .cfg_we, .nvm_load_pulse, .nvm_save_pulse, .meas_start,
   .continuous_run_flag, .change_watch_flag, .one_shot_flag);

// ### dv/shci_spi_master.sv
// SPI mode 3 bus master standing in for the host controller
`timescale 1ns/1ps
module shci_spi_master (
   // Link pins
   output logic ser_clk,
   output logic proto_sel_pin,
   output logic data_i,
   // Device drive of the shared line
   input wire logic data_o,
   input wire logic data_oe
);
   logic drv = 1'b0;
   logic mosi = 1'b1;
   initial begin
      ser_clk = 1'b1;
      proto_sel_pin = 1'b1;
   end
   // Released line is pulled up; wired-AND so the device can pull low under a released master
   assign data_i = (drv ? mosi : 1'b1) & (data_oe ? data_o : 1'b1);
   // select low per command, clock idles high
   task automatic xfer(input logic [31:0] c, input int nc, input int nr, output logic [71:0] r);
      r = '0;
      proto_sel_pin = 1'b0;
      drv = 1'b1;
      #20;
      // whole bytes, MSB first, shared line
      for (int i = 0; i < nc * 8; i++) begin
         ser_clk = 1'b0;
         mosi = c[31 - i];
         #16;
         ser_clk = 1'b1;
         #16;
      end
      drv = 1'b0;
      // Reply must cross into the core clock before it shifts out
      #500;
      for (int i = 0; i < nr * 8; i++) begin
         ser_clk = 1'b0;
         #16;
         r[71 - i] = data_i;
         ser_clk = 1'b1;
         #16;
      end
      #20;
      proto_sel_pin = 1'b1;
      #200;
   endtask : xfer
   // One SCL period per bit; data changes only while SCL is low
   task automatic i2c_bit(input logic b, output logic s);
      mosi = b;
      #100;
      ser_clk = 1'b1;
      #100;
      s = data_i;
      #100;
      ser_clk = 1'b0;
      #100;
   endtask : i2c_bit
   task automatic i2c_wr(input logic [7:0] b, inout logic nak);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         i2c_bit(b[i], s);
      end
      i2c_bit(1'b1, s);
      nak = nak | s;
   endtask : i2c_wr
   // address write, commands, restart, address read, reply
   task automatic i2c(input logic [6:0] a, input logic [31:0] c, input int nc, input int nr, output logic [71:0] r,
      output logic nak);
      logic s;
      r = '0;
      nak = 1'b0;
      drv = 1'b1;
      mosi = 1'b1;
      #200;
      mosi = 1'b0;
      #200;
      ser_clk = 1'b0;
      #100;
      i2c_wr({a, 1'b0}, nak);
      for (int i = 0; i < nc; i++) begin
         i2c_wr(c[31 - 8 * i -: 8], nak);
      end
      if (nr > 0) begin
         mosi = 1'b1;
         #100;
         ser_clk = 1'b1;
         #200;
         mosi = 1'b0;
         #200;
         ser_clk = 1'b0;
         #100;
         i2c_wr({a, 1'b1}, nak);
         for (int i = 0; i < nr * 8; i++) begin
            i2c_bit(1'b1, r[71 - i]);
            if (i % 8 == 7) begin
               i2c_bit(i == nr * 8 - 1, s);
            end
         end
      end
      mosi = 1'b0;
      #100;
      ser_clk = 1'b1;
      #200;
      mosi = 1'b1;
      #200;
      drv = 1'b0;
   endtask : i2c
endmodule : shci_spi_master

// ### dv/tb_top.sv
// Self-checking bench driving the command interface over SPI and I2C
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ser_clk, proto_sel_pin, data_i, data_o, data_oe, cfg_we, nvm_load_pulse, nvm_save_pulse, meas_start;
   logic [1:0] iface_lock_field = 2'h2;
   logic [3:0] default_axes = 4'hb;
   logic ecc_double = 1'b0;
   logic sample_done = 1'b0;
   logic saw_load = 1'b0;
   logic saw_save = 1'b0;
   logic trig_en = 1'b0;
   logic trig = 1'b0;
   logic ecc_single = 1'b0;
   logic nak;
   logic [5:0] cfg_addr, got_addr;
   logic [15:0] cfg_wdata, got_wdata;
   logic [3:0] meas_axes;
   logic continuous_run_flag, change_watch_flag, one_shot_flag, sample_ready_signal;
   logic [71:0] rsp;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   shci_pkg::shci_sample_t sample = 64'h4444_3333_2222_1111;
   shci_core shci_core_i (.core_clk, .rst, .proto_sel_pin, .ser_clk, .data_i, .data_o, .data_oe, .iface_lock_field,
      .stored_addr_bits(5'h03), .addr_pins(2'h0), .default_axes, .trig_enable(trig_en), .trigger_pin(trig),
      .ecc_double, .ecc_single, .cfg_addr, .cfg_wdata, .cfg_we, .cfg_rdata({10'h280, cfg_addr}),
      .nvm_load_pulse, .nvm_save_pulse, .meas_start, .meas_axes, .sample_done, .sample, .continuous_run_flag,
      .change_watch_flag, .one_shot_flag, .sample_ready_signal);
   shci_spi_master shci_spi_master_i (.ser_clk, .proto_sel_pin, .data_i, .data_o, .data_oe);
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cfg_we) begin
         got_addr <= cfg_addr;
         got_wdata <= cfg_wdata;
      end
      if (nvm_load_pulse) begin
         saw_load <= 1'b1;
      end
      if (nvm_save_pulse) begin
         saw_save <= 1'b1;
      end
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic send(input logic [31:0] c, input int nc, input int nr);
      @(negedge core_clk);
      shci_spi_master_i.xfer(c, nc, nr, rsp);
   endtask : send
   task automatic ic(input logic [6:0] a, input logic [31:0] c, input int nc, input int nr);
      @(negedge core_clk);
      shci_spi_master_i.i2c(a, c, nc, nr, rsp, nak);
   endtask : ic
   // Status bits 7..2 only; the length code means nothing here
   task automatic cmd1(input logic [7:0] op, input logic [5:0] e);
      send({op, 24'h0}, 1, 1);
      chk(64'(rsp[71:66]), 64'(e));
   endtask : cmd1
   task automatic end_sim();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      cmd1(8'h80, 6'h01);
      cmd1(8'h80, 6'h00);
      cmd1(8'h15, 6'h20);
      chk(64'(meas_axes), 64'h5);
      cmd1(8'h25, 6'h24);
      cmd1(8'h90, 6'h24);
      cmd1(8'h80, 6'h00);
      cmd1(8'h30, 6'h08);
      chk(64'(meas_axes), 64'hb);
      @(negedge core_clk) sample_done = 1'b1;
      @(negedge core_clk) sample_done = 1'b0;
      repeat (2) @(negedge core_clk);
      chk(64'({sample_ready_signal, one_shot_flag}), 64'h2);
      send(32'h4f00_0000, 1, 9);
      chk(64'(rsp[71:64]), 64'h03);
      chk(rsp[63:0], 64'h1111_2222_3333_4444);
      chk(64'(sample_ready_signal), 64'h0);
      cmd1(8'h41, 6'h04);
      send(32'h6012_3414, 4, 1);
      chk({42'h0, got_addr, got_wdata}, 64'h05_1234);
      chk(64'(rsp[71:66]), 64'h0);
      send(32'h60ff_ff80, 4, 1);
      chk(64'(rsp[71:66]), 64'h04);
      send(32'h5014_0000, 2, 3);
      chk(64'(rsp[71:48]), 64'h00_a005);
      @(negedge core_clk) ecc_double = 1'b1;
      cmd1(8'h15, 6'h04);
      @(negedge core_clk) ecc_double = 1'b0;
      send(32'hf000_0000, 1, 0);
      repeat (4) @(negedge core_clk);
      chk(64'(saw_load), 64'h1);
      cmd1(8'h80, 6'h01);
      @(negedge core_clk) iface_lock_field = 2'h3;
      send(32'h8000_0000, 1, 1);
      chk(64'(rsp[71:64]), 64'h04);
      ic(7'h0c, 32'h9000_0000, 1, 1);
      chk(64'({nak, rsp[71:64]}), 64'h010);
      @(negedge core_clk) ecc_single = 1'b1;
      ic(7'h0c, 32'h2e00_0000, 1, 1);
      chk(64'({change_watch_flag, rsp[71:64]}), 64'h148);
      ic(7'h0c, 32'h5014_0000, 2, 3);
      chk(64'(rsp[71:48]), 64'h48_a005);
      ic(7'h0d, 32'h8000_0000, 1, 0);
      chk(64'({nak, change_watch_flag}), 64'h3);
      ic(7'h0c, 32'h8000_0000, 1, 1);
      chk(64'({change_watch_flag, rsp[71:64]}), 64'h008);
      ic(7'h0c, 32'he000_0000, 1, 1);
      chk(64'({saw_save, rsp[71:64]}), 64'h108);
      @(negedge core_clk) trig = 1'b1;
      repeat (5) @(negedge core_clk);
      chk(64'(one_shot_flag), 64'h0);
      trig = 1'b0;
      trig_en = 1'b1;
      repeat (5) @(negedge core_clk);
      trig = 1'b1;
      repeat (5) @(negedge core_clk);
      chk(64'({one_shot_flag, meas_axes}), 64'h1b);
      end_sim();
   end
endmodule : tb_top
